// ### subaddress_correlation_encoder.sv
// Subaddress correlation encoder: builds and streams one subaddress element
`timescale 1ns/10ps
`default_nettype none
`include "subaddress_correlation_encoder_regs.svh"

module subaddress_correlation_encoder (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic sel_calling,
    input wire logic var_len,
    input wire logic tele_only_fill,
    input wire logic [19:0] network_owner_code,
    input wire logic [2:0] network_owner_count,
    input wire logic [31:0] comm_identity_number,
    input wire logic [3:0] comm_identity_count,
    input wire logic [31:0] content_link_ident,
    input wire logic [3:0] content_link_count,
    input wire logic natl_present,
    input wire logic [63:0] natl_nibbles,
    input wire logic [4:0] natl_count,
    input wire logic [99:0] intercept_ident,
    input wire logic [4:0] intercept_count,
    input wire logic [3:0] direction,
    input wire logic direction_valid,
    input wire logic medium_valid,
    input wire logic [7:0] transmission_medium_req,
    input wire logic bearer_cap_valid,
    input wire logic [7:0] bearer_capability_octet,
    input wire logic compat_valid,
    input wire logic [7:0] high_layer_compat_octet,
    input wire logic mbsc_valid,
    input wire logic [7:0] mobile_bearer_code,
    input wire logic mtsc_valid,
    input wire logic [7:0] mobile_tele_code,
    input wire logic out_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    output logic busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Non-decimal input is forced to zero so F never appears inside a field other than the national one
    function automatic subaddress_correlation_encoder_pkg::nibble_t digit_nib(
        input logic [3:0] d
    );
        digit_nib = (d > 4'h9) ? `SCE_ZERO_NIB : d;
    endfunction

    subaddress_correlation_encoder_pkg::enc_state_e state_reg;
    subaddress_correlation_encoder_pkg::nibble_t nib [0:`SCE_NIB_MAX-1];
    subaddress_correlation_encoder_pkg::octet_t oct_next [0:`SCE_OCT_MAX-1];
    subaddress_correlation_encoder_pkg::octet_t mem_reg [0:`SCE_OCT_MAX-1];
    logic [5:0] nib_count;
    logic [4:0] total_next;
    logic [4:0] total_reg;
    logic [4:0] idx_reg;
    logic take;

    assign take = start && (state_reg == subaddress_correlation_encoder_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Nibble stream

    always_comb
    begin
        int n;
        n = 0;
        // Digits past a field's count land where its separator then goes
        for (int i = 0; i < `SCE_NIB_MAX; i++)
        begin
            nib[i] = `SCE_ZERO_NIB;
        end
        if (sel_calling)
        begin
            for (int i = 0; i < `SCE_LID_MAX; i++)
            begin
                nib[n] = digit_nib(intercept_ident[i*4 +: 4]);
                n += int'(i < int'(intercept_count));
            end
            nib[n] = `SCE_SEP_NIB;
            n++;
            if (direction_valid)
            begin
                nib[n] = digit_nib(direction);
                n++;
            end
            nib[n] = `SCE_SEP_NIB;
            n++;
        end
        else
        begin
            for (int i = 0; i < `SCE_OWNER_MAX; i++)
            begin
                nib[n] = digit_nib(network_owner_code[i*4 +: 4]);
                n += int'(i < int'(network_owner_count));
            end
            nib[n] = `SCE_SEP_NIB;
            n++;
            for (int i = 0; i < `SCE_IDENT_MAX; i++)
            begin
                nib[n] = digit_nib(comm_identity_number[i*4 +: 4]);
                n += int'(i < int'(comm_identity_count));
            end
            nib[n] = `SCE_SEP_NIB;
            n++;
            for (int i = 0; i < `SCE_CCL_MAX; i++)
            begin
                nib[n] = digit_nib(content_link_ident[i*4 +: 4]);
                n += int'(i < int'(content_link_count));
            end
            nib[n] = `SCE_SEP_NIB;
            n++;
            if (natl_present)
            begin
                for (int i = 0; i < `SCE_NATL_MAX; i++)
                begin
                    if (i < int'(natl_count))
                    begin
                        nib[n] = natl_nibbles[i*4 +: 4];
                        n++;
                    end
                end
            end
        end
        nib_count = n[5:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Octet image

    always_comb
    begin
        int body;
        int pos;
        body = (int'(nib_count) + 1) / 2;
        pos = 0;
        for (int k = 0; k < `SCE_OCT_MAX - `SCE_HDR_OCTS; k++)
        begin
            oct_next[k + `SCE_HDR_OCTS] = {nib[2*k], nib[2*k+1]};
        end
        oct_next[2] = `SCE_TYPE_OCT;
        if (sel_calling)
        begin
            oct_next[0] = `SCE_CALLING_IE_ID;
            pos = var_len ? (`SCE_HDR_OCTS + body) : `SCE_SVC_IDX;
            oct_next[pos] = medium_valid ? transmission_medium_req : `SCE_FILL_OCT;
            oct_next[pos+1] = bearer_cap_valid ? bearer_capability_octet : `SCE_FILL_OCT;
            oct_next[pos+2] = compat_valid ? high_layer_compat_octet : `SCE_FILL_OCT;
            pos = pos + 3;
            if (mbsc_valid && mtsc_valid)
            begin
                oct_next[pos] = mobile_bearer_code;
                oct_next[pos+1] = mobile_tele_code;
                pos = pos + 2;
            end
            else if (mbsc_valid)
            begin
                oct_next[pos] = mobile_bearer_code;
                pos = pos + 1;
            end
            else if (mtsc_valid && tele_only_fill)
            begin
                oct_next[pos] = `SCE_FILL_OCT;
                oct_next[pos+1] = mobile_tele_code;
                pos = pos + 2;
            end
            // Otherwise both mobile octets are left out
        end
        else
        begin
            oct_next[0] = `SCE_CALLED_IE_ID;
            pos = var_len ? (`SCE_HDR_OCTS + body) : `SCE_CALLED_FIXED;
            oct_next[2][`SCE_ODD_BIT] = !natl_present && nib_count[0];
        end
        oct_next[1] = 8'(pos - 2);
        total_next = pos[4:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture and stream control

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int k = 0; k < `SCE_OCT_MAX; k++)
            begin
                mem_reg[k] <= 8'h00;
            end
            total_reg <= 5'h00;
        end
        else if (take)
        begin
            for (int k = 0; k < `SCE_OCT_MAX; k++)
            begin
                mem_reg[k] <= oct_next[k];
            end
            total_reg <= total_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= subaddress_correlation_encoder_pkg::ST_IDLE;
            idx_reg <= 5'h00;
            out_valid <= 1'b0;
            out_data <= 8'h00;
            out_last <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            case (state_reg)
                subaddress_correlation_encoder_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        state_reg <= subaddress_correlation_encoder_pkg::ST_SEND;
                        idx_reg <= 5'h00;
                        out_valid <= 1'b1;
                        out_data <= oct_next[0];
                        out_last <= 1'b0;
                        busy <= 1'b1;
                    end
                end
                subaddress_correlation_encoder_pkg::ST_SEND:
                begin
                    if (out_ready)
                    begin
                        if (out_last)
                        begin
                            state_reg <= subaddress_correlation_encoder_pkg::ST_IDLE;
                            out_valid <= 1'b0;
                            out_last <= 1'b0;
                            busy <= 1'b0;
                        end
                        else
                        begin
                            idx_reg <= idx_reg + 5'h01;
                            out_data <= mem_reg[idx_reg + 5'h01];
                            out_last <= ((idx_reg + 5'h02) == total_reg);
                        end
                    end
                end
                default:
                begin
                    state_reg <= subaddress_correlation_encoder_pkg::ST_IDLE;
                    out_valid <= 1'b0;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_hold_until_taken;
        @(posedge clk) disable iff (!arst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold_until_taken: assert property (p_hold_until_taken)
        else $error("Octet changed while not accepted");

    property p_length_octet;
        @(posedge clk) disable iff (!arst_n)
        out_valid && idx_reg == 5'h01 |-> out_data == 8'(total_reg - 5'h02);
    endproperty
    a_length_octet: assert property (p_length_octet)
        else $error("Octet 2 does not hold the element length");

    property p_calling_full;
        @(posedge clk) disable iff (!arst_n)
        take && sel_calling && !var_len && mbsc_valid && mtsc_valid |=> total_reg == 5'h17;
    endproperty
    a_calling_full: assert property (p_calling_full)
        else $error("Fixed calling element with both mobile octets is not 23");

    property p_calling_short;
        @(posedge clk) disable iff (!arst_n)
        take && sel_calling && !var_len && !mbsc_valid |=>
            total_reg == (($past(mtsc_valid) && $past(tele_only_fill)) ? 5'h17 : 5'h15);
    endproperty
    a_calling_short: assert property (p_calling_short)
        else $error("Fixed calling element length wrong without bearer code");

    property p_bearer_only;
        @(posedge clk) disable iff (!arst_n)
        take && sel_calling && !var_len && mbsc_valid && !mtsc_valid |=>
            total_reg == 5'h16 && mem_reg[21] == $past(mobile_bearer_code);
    endproperty
    a_bearer_only: assert property (p_bearer_only)
        else $error("Bearer-only element is not 22 octets");

    property p_tele_fill;
        @(posedge clk) disable iff (!arst_n)
        take && sel_calling && !var_len && !mbsc_valid && mtsc_valid && tele_only_fill |=>
            mem_reg[21] == 8'hFF && mem_reg[22] == $past(mobile_tele_code);
    endproperty
    a_tele_fill: assert property (p_tele_fill)
        else $error("Teleservice-only fill option not applied");

    property p_medium_fill;
        @(posedge clk) disable iff (!arst_n)
        take && sel_calling && !var_len && !medium_valid |=> mem_reg[18] == 8'hFF;
    endproperty
    a_medium_fill: assert property (p_medium_fill)
        else $error("Missing medium octet not filled");

    property p_empty_owner;
        @(posedge clk) disable iff (!arst_n)
        take && !sel_calling && network_owner_count == 3'h0 |=> mem_reg[3][7:4] == 4'hF;
    endproperty
    a_empty_owner: assert property (p_empty_owner)
        else $error("Empty owner field is not a lone separator");

    property p_digit_pair;
        @(posedge clk) disable iff (!arst_n)
        take && sel_calling && intercept_count > 5'h01
            && intercept_ident[3:0] < 4'hA && intercept_ident[7:4] < 4'hA |=>
            mem_reg[3] == {$past(intercept_ident[3:0]), $past(intercept_ident[7:4])};
    endproperty
    a_digit_pair: assert property (p_digit_pair)
        else $error("Digit pair packed in wrong halves");

    property p_odd_even;
        @(posedge clk) disable iff (!arst_n)
        take && !sel_calling && !natl_present |=> mem_reg[2][3] == $past(nib_count[0]);
    endproperty
    a_odd_even: assert property (p_odd_even)
        else $error("Odd/even indicator wrong");

endmodule // subaddress_correlation_encoder

`default_nettype wire

// ### subaddress_correlation_encoder_pkg.sv
// Types for the subaddress correlation encoder
`default_nettype none

package subaddress_correlation_encoder_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } enc_state_e;

    typedef logic [7:0] octet_t;
    typedef logic [3:0] nibble_t;

endpackage

`default_nettype wire

// ### subaddress_correlation_encoder_regs.svh
// Constants for the subaddress correlation encoder
`ifndef SUBADDRESS_CORRELATION_ENCODER_REGS_SVH
`define SUBADDRESS_CORRELATION_ENCODER_REGS_SVH

`define SCE_SEP_NIB 4'hF
`define SCE_ZERO_NIB 4'h0
`define SCE_FILL_OCT 8'hFF
`define SCE_TYPE_OCT 8'hA0
`define SCE_ODD_BIT 3
`define SCE_OWNER_MAX 5
`define SCE_IDENT_MAX 8
`define SCE_CCL_MAX 8
`define SCE_NATL_MAX 16
`define SCE_LID_MAX 25
`define SCE_NIB_MAX 48
`define SCE_OCT_MAX 24
`define SCE_HDR_OCTS 3
`define SCE_SVC_IDX 18
`define SCE_CALLED_FIXED 23
`define SCE_CALLING_FULL 23
`define SCE_CALLING_SHORT 21
`define SCE_CALLED_IE_ID 8'h01
`define SCE_CALLING_IE_ID 8'h02

`endif

// ### subaddress_receiver_model.sv
// Receiving side model that accepts octets with optional stalls
`timescale 1ns/10ps
`default_nettype none

module subaddress_receiver_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic out_valid,
    output logic out_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // Ready generation: prompt, or two octets accepted back to back, then four idle cycles
    logic [1:0] stall_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stall_reg <= 2'h0;
            out_ready <= 1'b0;
        end
        else
        begin
            if (out_valid && out_ready)
                stall_reg <= 2'h3;
            else if (stall_reg != 2'h0)
                stall_reg <= stall_reg - 2'h1;
            out_ready <= !slow || (stall_reg == 2'h0);
        end
    end

endmodule // subaddress_receiver_model

`default_nettype wire

// ### tb_subaddress_correlation_encoder.sv
// Self-checking testbench for the subaddress correlation encoder
`timescale 1ns/10ps
`default_nettype none
`include "subaddress_correlation_encoder_regs.svh"

module tb_subaddress_correlation_encoder;

    logic clk, arst_n, start, sel_calling, var_len, tele_only_fill, slow;
    logic [19:0] network_owner_code;
    logic [2:0] network_owner_count;
    logic [31:0] comm_identity_number, content_link_ident;
    logic [3:0] comm_identity_count, content_link_count, direction;
    logic natl_present, direction_valid, medium_valid, bearer_cap_valid, compat_valid;
    logic mbsc_valid, mtsc_valid;
    logic [63:0] natl_nibbles;
    logic [4:0] natl_count, intercept_count;
    logic [99:0] intercept_ident;
    logic [7:0] transmission_medium_req, bearer_capability_octet, high_layer_compat_octet;
    logic [7:0] mobile_bearer_code, mobile_tele_code, out_data;
    logic out_ready, out_valid, out_last, busy;
    int num_errors = 0;
    int check_count = 0;
    int unsigned rng_state = 97183;
    logic [8:0] exp_q[$];
    subaddress_correlation_encoder_pkg::nibble_t nib[$];

    subaddress_correlation_encoder i_subaddress_correlation_encoder (
        .clk(clk), .arst_n(arst_n), .start(start), .sel_calling(sel_calling),
        .var_len(var_len), .tele_only_fill(tele_only_fill),
        .network_owner_code(network_owner_code), .network_owner_count(network_owner_count),
        .comm_identity_number(comm_identity_number), .comm_identity_count(comm_identity_count),
        .content_link_ident(content_link_ident), .content_link_count(content_link_count),
        .natl_present(natl_present), .natl_nibbles(natl_nibbles), .natl_count(natl_count),
        .intercept_ident(intercept_ident), .intercept_count(intercept_count),
        .direction(direction), .direction_valid(direction_valid),
        .medium_valid(medium_valid), .transmission_medium_req(transmission_medium_req),
        .bearer_cap_valid(bearer_cap_valid), .bearer_capability_octet(bearer_capability_octet),
        .compat_valid(compat_valid), .high_layer_compat_octet(high_layer_compat_octet),
        .mbsc_valid(mbsc_valid), .mobile_bearer_code(mobile_bearer_code),
        .mtsc_valid(mtsc_valid), .mobile_tele_code(mobile_tele_code),
        .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .busy(busy));
    subaddress_receiver_model i_subaddress_receiver_model (.clk(clk), .arst_n(arst_n),
        .slow(slow), .out_valid(out_valid), .out_ready(out_ready));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic int unsigned xs();
        rng_state ^= rng_state << 13;
        rng_state ^= rng_state >> 17;
        rng_state ^= rng_state << 5;
        return rng_state;
    endfunction

    function automatic int pick(input int mx, input int k);
        if (k == 1)
            return mx;
        if (k == 2)
            return 0;
        return xs() % (mx + 1);
    endfunction

    function automatic logic [99:0] digits();
        logic [99:0] d;
        for (int i = 0; i < 25; i++)
            d[4*i+:4] = 4'(xs() % 10);
        return d;
    endfunction

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic add_digits(input logic [99:0] v, input int cnt);
        for (int i = 0; i < cnt; i++)
            nib.push_back(v[4*i+:4]);
        nib.push_back(`SCE_SEP_NIB);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Driver: fields, expected octets, start
    task automatic set_fields(input int t);
        int k;
        k = t % 5;
        sel_calling <= t[0];
        var_len <= t[1];
        mbsc_valid <= t[2];
        mtsc_valid <= t[3];
        tele_only_fill <= t[4];
        slow <= 1'(xs() % 2);
        network_owner_code <= 20'(digits());
        network_owner_count <= 3'(pick(5, k));
        comm_identity_number <= 32'(digits());
        comm_identity_count <= 4'(pick(8, k));
        content_link_ident <= 32'(digits());
        content_link_count <= 4'(pick(8, k));
        natl_present <= 1'(xs() % 2);
        natl_nibbles <= {xs(), xs()};
        natl_count <= 5'(pick(16, k));
        intercept_ident <= digits();
        intercept_count <= 5'(pick(25, k));
        direction <= (t == 11) ? 4'hC : 4'(xs() % 10);
        direction_valid <= k != 2 && (k == 1 || xs() % 2 == 1);
        medium_valid <= k == 1 || xs() % 2 == 1;
        bearer_cap_valid <= k == 1 || xs() % 2 == 1;
        compat_valid <= k == 1 || xs() % 2 == 1;
        transmission_medium_req <= 8'(xs());
        bearer_capability_octet <= 8'(xs());
        high_layer_compat_octet <= 8'(xs());
        mobile_bearer_code <= 8'(xs());
        mobile_tele_code <= 8'(xs());
    endtask

    task automatic build_expected();
        subaddress_correlation_encoder_pkg::octet_t oct[$];
        logic odd;
        nib = {};
        if (sel_calling)
        begin
            add_digits(intercept_ident, intercept_count);
            if (direction_valid)
                nib.push_back(direction > 4'h9 ? `SCE_ZERO_NIB : direction);
            nib.push_back(`SCE_SEP_NIB);
        end
        else
        begin
            add_digits(100'(network_owner_code), network_owner_count);
            add_digits(100'(comm_identity_number), comm_identity_count);
            add_digits(100'(content_link_ident), content_link_count);
            for (int i = 0; i < natl_count && natl_present; i++)
                nib.push_back(natl_nibbles[4*i+:4]);
        end
        odd = !sel_calling && !natl_present && nib.size() % 2 == 1;
        if (nib.size() % 2 == 1)
            nib.push_back(`SCE_ZERO_NIB);
        for (int i = 0; i < nib.size(); i += 2)
            oct.push_back({nib[i], nib[i+1]});
        if (sel_calling)
        begin
            while (!var_len && oct.size() < 15)
                oct.push_back(8'h00);
            oct.push_back(medium_valid ? transmission_medium_req : `SCE_FILL_OCT);
            oct.push_back(bearer_cap_valid ? bearer_capability_octet : `SCE_FILL_OCT);
            oct.push_back(compat_valid ? high_layer_compat_octet : `SCE_FILL_OCT);
            if (mbsc_valid)
                oct.push_back(mobile_bearer_code);
            else if (mtsc_valid && tele_only_fill)
                oct.push_back(`SCE_FILL_OCT);
            if (mtsc_valid && (mbsc_valid || tele_only_fill))
                oct.push_back(mobile_tele_code);
        end
        while (!sel_calling && !var_len && oct.size() < 20)
            oct.push_back(8'h00);
        exp_q.push_back({1'b0, sel_calling ? `SCE_CALLING_IE_ID : `SCE_CALLED_IE_ID});
        exp_q.push_back({1'b0, 8'(oct.size() + 1)});
        exp_q.push_back({1'b0, `SCE_TYPE_OCT | {4'h0, odd, 3'h0}});
        foreach (oct[i])
            exp_q.push_back({i == oct.size() - 1, oct[i]});
    endtask

    task automatic run_elem(input int t);
        int n;
        @(posedge clk);
        set_fields(t);
        #1;
        build_expected();
        @(posedge clk);
        start <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            start <= (t == 5 && n == 3);
            n++;
            #1;
        end
        while ((busy !== 1'b0 || n < 2) && n < 3000);
        if (n >= 3000)
            num_errors++;
        check(9'(exp_q.size()), 9'h000);
        check({out_valid, 8'h00}, 9'h000);
        $display("test %0d done", t);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: each accepted octet is compared with the oldest note
    always @(posedge clk)
    begin
        if (arst_n && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            check(9'(busy), 9'h001);
            if (exp_q.size() == 0)
                check({out_last, out_data}, 9'h1FF);
            else
                check({out_last, out_data}, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock, reset, sequence, watchdog
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        {arst_n, start, sel_calling, var_len, tele_only_fill, slow} = 6'h00;
        {network_owner_code, network_owner_count, comm_identity_number} = '0;
        {comm_identity_count, content_link_ident, content_link_count} = '0;
        {natl_present, natl_nibbles, natl_count, intercept_ident, intercept_count} = '0;
        {direction, direction_valid, medium_valid, bearer_cap_valid, compat_valid} = '0;
        {transmission_medium_req, bearer_capability_octet, high_layer_compat_octet} = '0;
        {mbsc_valid, mobile_bearer_code, mtsc_valid, mobile_tele_code} = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int t = 0; t < 40; t++)
            run_elem(t);
        final_report();
    end

    initial
    begin
        #400000;
        num_errors++;
        final_report();
    end

endmodule // tb_subaddress_correlation_encoder

`default_nettype wire
